// [hb_host_model.sv]
// host master model driving the serial link
// serial clock runs only inside frames, 15 ns period, idle low
`timescale 1ns/10ps
`default_nettype none
module hb_host_model (
  output var logic sclk,
  output var logic chip_select_n,
  output var logic serial_in,
  input wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // one frame of nbits, lsb first; status taken on each rising edge
  task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [31:0] st);
    st = 32'h0000_0000;
    chip_select_n = 1'b0;
    #150;
    for (int i = 0; i < nbits; i++) begin
      serial_in = cmd[i];
      #7.5 sclk = 1'b1;
      st[i] = serial_out;
      #7.5 sclk = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #450;
  endtask
endmodule
`default_nettype wire

// [hb_pkg.sv]
// package for the six-channel half-bridge serial control block
// assumes a 10 MHz system clock and a host-driven serial clock
package hb_pkg;

  // word layout
  localparam int          WORD_W        = 16;
  localparam int          CNT_W         = 5;
  localparam int          NUM_CH        = 6;
  localparam int          NUM_DRV       = 12;
  localparam logic [4:0]  WORD_BITS     = 5'h10;
  localparam logic [4:0]  LAST_BIT      = 5'h0F;

  // command word fields
  localparam int          CMD_OV_SHUT   = 15;
  localparam int          CMD_UL_SHUT   = 14;
  localparam int          CMD_OC_SHUT   = 13;
  localparam int          CMD_DRV_MSB   = 12;
  localparam int          CMD_DRV_LSB   = 1;
  localparam int          CMD_CLEAR     = 0;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  // status word fields
  localparam int          ST_SUPPLY     = 15;
  localparam int          ST_UNDERLOAD  = 14;
  localparam int          ST_OVERLOAD   = 13;
  localparam int          ST_THERMAL    = 0;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;

  // timing, figures in their own units
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          UL_DELAY_US   = 350;
  localparam int          HL_GAP_NS     = 1500;
  localparam int          LH_GAP_NS     = 2500;
  localparam int          UL_W          = 12;
  localparam int          GAP_W         = 5;
  localparam logic [UL_W-1:0]  UL_CYCLES =
    UL_W'((UL_DELAY_US * 1000) / CLK_PERIOD_NS);
  localparam logic [GAP_W-1:0] HL_CYCLES =
    GAP_W'((HL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [GAP_W-1:0] LH_CYCLES =
    GAP_W'((LH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [GAP_W-1:0] GAP_MAX   = 5'h1F;

  // fault sense inputs from the analog monitors
  typedef struct packed {
    logic               overvoltage;
    logic               undervoltage;
    logic               thermal_warning;
    logic               over_temperature;
    logic [NUM_DRV-1:0] underload;
    logic [NUM_DRV-1:0] overcurrent;
  } hb_fault_t;

endpackage

// [hb_spi_control.sv]
// serial control and diagnostics of a six-channel half-bridge driver
// assumes sclk idles between frames; faults arrive as asynchronous levels
// What this block does
// - each frame: sixteen bits in, sixteen out
// - both words shift least significant bit first
// - select rising edge loads and applies command
// - serial output released while select is high
// - status shifts out while command shifts in
// - output feeds next device input when chained
// - bit 15 enables overvoltage shutdown
// - bit 14 enables under-load shutdown
// - bit 13 enables overcurrent shutdown, else flag only
// - bits 1..12 switch low and high drivers
// - bit 0 clears latched status flags
// - status 15 reports supply fault
// - status 14 reports under-load fault
// - status 13 reports overcurrent fault
// - status 1..12 return driver on states
// - under-load flagged after 350 us persistence
// - dead time 1.5 us and 2.5 us per channel
// - sleep loses all command and status data
// - lost select reads high, lost enable low
// - enable high wakes, enable low sleeps
// - thermal warning latched until status clear
// - under-load shutdown latches driver off
// - overvoltage forces all off, settings kept
`timescale 1ns/10ps
`default_nettype none

module hb_spi_control
  import hb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        chip_select_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en,
  input  wire logic        enable,
  input  wire hb_fault_t   fault_in,
  output logic [NUM_CH-1:0] low_side,
  output logic [NUM_CH-1:0] high_side
);

  // system clock state
  typedef struct packed {
    logic [1:0]                    cs_sync;
    logic [1:0]                    en_sync;
    hb_fault_t                     fault_s1;
    hb_fault_t                     fault_s2;
    logic                          cs_prev;
    logic [WORD_W-1:0]             cmd;
    logic [NUM_DRV-1:0]            drv;
    logic [NUM_DRV-1:0]            off_latch;
    logic                          supply_fault_flag;
    logic                          underload_flag;
    logic                          overload_flag;
    logic                          thermal_warning_flag;
    logic [NUM_DRV-1:0][UL_W-1:0]  ul_cnt;
    logic [NUM_CH-1:0][GAP_W-1:0]  hs_gap;
    logic [NUM_CH-1:0][GAP_W-1:0]  ls_gap;
    logic [WORD_W-1:0]             status_hold;
  } hb_state_t;

  // link state reset by the frame itself
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } hb_rise_t;

  // link state that must survive the frame end
  typedef struct packed {
    logic [WORD_W-1:0] rx;
    logic              got_word;
  } hb_shift_t;

  // falling edge state
  typedef struct packed {
    logic so_bit;
    logic started;
  } hb_fall_t;

  // constant state after reset: select deselected, enable low
  localparam hb_state_t STATE_RESET = '{
    cs_sync:              2'h3,
    en_sync:              2'h0,
    fault_s1:             '0,
    fault_s2:             '0,
    cs_prev:              1'h1,
    cmd:                  CMD_RESET,
    drv:                  '0,
    off_latch:            '0,
    supply_fault_flag:    1'h0,
    underload_flag:       1'h0,
    overload_flag:        1'h0,
    thermal_warning_flag: 1'h0,
    ul_cnt:               '0,
    hs_gap:               '0,
    ls_gap:               '0,
    status_hold:          STATUS_RESET
  };

  hb_state_t s;
  hb_state_t next_s;
  hb_rise_t  r;
  hb_rise_t  next_r;
  hb_shift_t sh;
  hb_shift_t next_sh;
  hb_fall_t  f;
  hb_fall_t  next_f;

  // ---------------- link clock domain ----------------

  // bit counter, saturates at sixteen, cleared while select is high
  // the count picks the status bit to show and tells whether a full
  // word arrived; saturating keeps it from wrapping on long chains,
  // where the output then falls back to the delayed receive path
  always_comb begin
    next_r = r;
    if (r.cnt != WORD_BITS) begin
      next_r.cnt = r.cnt + 5'h01;
    end
  end

  // frame signal ends the count, so no edge is needed after the frame
  // select high clears the counter at once; the host never has to give
  // an extra link clock edge to tidy up after a frame
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // receive shifter, lsb arrives first and moves down
  // after sixteen or more edges the register holds the last sixteen
  // bits with the earliest of them at bit 0; the word flag marks that
  // the sixteenth edge was seen, so a short frame leaves it low
  always_comb begin
    next_sh          = sh;
    next_sh.rx       = {serial_in, sh.rx[WORD_W-1:1]};
    next_sh.got_word = (r.cnt >= LAST_BIT);
  end

  // sampled on the rising edge; held stable once the frame ends
  // no reset here: the shifter must keep its word past the select edge
  // until the system clock side has taken it
  always_ff @(posedge sclk) begin
    sh <= next_sh;
  end

  // output bit: status first, then bits received sixteen clocks back
  // the status word is read across domains; it is only refreshed while
  // the synchronised select is high, so a host must leave a few system
  // clocks between select falling and the first falling link edge
  always_comb begin
    next_f         = f;
    next_f.started = 1'h1;
    if (r.cnt < WORD_BITS) begin
      next_f.so_bit = s.status_hold[r.cnt[3:0]];
    end else begin
      next_f.so_bit = sh.rx[0];
    end
  end

  // output changes on the falling edge, opposite to sampling
  // this gives a master sampling on the rising edge half a link period
  // of settled data; select high clears the flops asynchronously
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // before the first falling edge the thermal bit is shown
  // the select path to the output enable is kept combinational so that
  // the pin is released as soon as select rises and the thermal bit is
  // visible without any link clock at all; sleep keeps the pin released
  assign serial_out    = f.started ? f.so_bit : s.status_hold[ST_THERMAL];
  assign serial_out_en = ~chip_select_n & s.en_sync[1];

  // ---------------- system clock domain ----------------

  logic               awake;
  logic               cs_rise;
  logic               take;
  logic               clr;
  logic               block_all;
  logic [NUM_DRV-1:0] ul_hit;
  logic [NUM_DRV-1:0] oc_hit;
  logic [NUM_DRV-1:0] want;
  logic [NUM_DRV-1:0] clr_v;

  // command load, fault latching, driver sequencing
  // select, enable and the fault levels come from outside this clock and
  // pass two flops each before any logic reads them; the select rising
  // edge is found one flop later, by which time the link clock is idle
  // and the received word can be taken without a further handshake
  always_comb begin
    next_s          = s;
    next_s.cs_sync  = {s.cs_sync[0], chip_select_n};
    next_s.en_sync  = {s.en_sync[0], enable};
    next_s.fault_s1 = fault_in;
    next_s.fault_s2 = s.fault_s1;
    next_s.cs_prev  = s.cs_sync[1];

    awake   = s.en_sync[1];
    cs_rise = s.cs_sync[1] & ~s.cs_prev;
    // word is quiet here: select is high and the link clock idles
    take    = cs_rise & awake & sh.got_word;
    clr     = take & sh.rx[CMD_CLEAR];
    clr_v   = {NUM_DRV{clr}};
    if (take) begin
      next_s.cmd = sh.rx;
    end

    // under-load persistence timers per driver
    // each timer runs only while its driver is on and the condition lasts;
    // any gap restarts it, so short dips never reach the flag
    ul_hit = '0;
    for (int i = 0; i < NUM_DRV; i++) begin
      if (s.drv[i] & s.fault_s2.underload[i]) begin
        if (s.ul_cnt[i] != UL_CYCLES) begin
          next_s.ul_cnt[i] = s.ul_cnt[i] + 12'h001;
        end
      end else begin
        next_s.ul_cnt[i] = '0;
      end
      ul_hit[i] = (s.ul_cnt[i] == UL_CYCLES);
    end
    oc_hit = s.fault_s2.overcurrent & s.drv;

    // latched shutdowns; a new fault wins over a clear
    // a latched driver stays off until a clear command arrives, even if
    // the host keeps asking for it in later commands
    next_s.off_latch = (s.off_latch & ~clr_v)
      | (ul_hit & {NUM_DRV{s.cmd[CMD_UL_SHUT]}})
      | (oc_hit & {NUM_DRV{s.cmd[CMD_OC_SHUT]}});

    // sticky status flags
    // every flag is set by the live condition and cleared only by the
    // clear bit or by sleep; a condition that is still present sets it again at once
    next_s.supply_fault_flag = (s.supply_fault_flag & ~clr)
      | s.fault_s2.overvoltage
      | s.fault_s2.undervoltage;
    next_s.underload_flag = (s.underload_flag & ~clr)
      | (|ul_hit);
    next_s.overload_flag = (s.overload_flag & ~clr)
      | (|oc_hit);
    next_s.thermal_warning_flag = (s.thermal_warning_flag & ~clr)
      | s.fault_s2.thermal_warning;

    // live conditions that force all drivers off, settings untouched
    // the command word is left alone, so the programmed drivers come
    // back by themselves once the condition has gone
    block_all = (s.fault_s2.overvoltage & s.cmd[CMD_OV_SHUT])
              | s.fault_s2.undervoltage | s.fault_s2.over_temperature;
    want = s.cmd[CMD_DRV_MSB:CMD_DRV_LSB] & ~s.off_latch
         & ~{NUM_DRV{block_all}};

    // per channel: off at once, on only after the dead time
    // each gap counter counts cycles since the opposite side was last on
    // and saturates; when both sides are asked for, the low side wins and
    // the high side stays off, so the two never conduct together
    for (int c = 0; c < NUM_CH; c++) begin
      next_s.drv[2*c] = want[2*c] & ~s.drv[2*c+1]
        & (s.hs_gap[c] >= HL_CYCLES);
      next_s.drv[2*c+1] = want[2*c+1] & ~want[2*c] & ~s.drv[2*c]
        & (s.ls_gap[c] >= LH_CYCLES);
      if (s.drv[2*c+1]) begin
        next_s.hs_gap[c] = '0;
      end else if (s.hs_gap[c] != GAP_MAX) begin
        next_s.hs_gap[c] = s.hs_gap[c] + 5'h01;
      end
      if (s.drv[2*c]) begin
        next_s.ls_gap[c] = '0;
      end else if (s.ls_gap[c] != GAP_MAX) begin
        next_s.ls_gap[c] = s.ls_gap[c] + 5'h01;
      end
    end

    // status snapshot, frozen while a frame is running
    // freezing keeps the word coherent while the link side reads it bit
    // by bit; bits 1..12 sit where the switch bits of the command word do
    if (s.cs_sync[1]) begin
      next_s.status_hold = {s.supply_fault_flag, s.underload_flag,
                            s.overload_flag, s.drv,
                            s.thermal_warning_flag};
    end

    // sleep: everything but the synchronisers returns to reset
    // nothing survives sleep, so the host must rewrite the command word
    // after wake-up; the synchronisers keep running so wake-up is seen
    if (!awake) begin
      next_s          = STATE_RESET;
      next_s.cs_sync  = {s.cs_sync[0], chip_select_n};
      next_s.en_sync  = {s.en_sync[0], enable};
      next_s.fault_s1 = fault_in;
      next_s.fault_s2 = s.fault_s1;
    end
  end

  // system state register
  // synchronous reset; the reset value leaves select deselected and the
  // block asleep until enable has passed its synchroniser
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // driver outputs straight from the driver state flops
  // even bits of the driver state are low sides, odd bits high sides,
  // in the same order as the switch bits of the command word
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      low_side[c]  = s.drv[2*c];
      high_side[c] = s.drv[2*c+1];
    end
  end

endmodule

`default_nettype wire

// [hb_spi_control_sva.sv]
// checker of the half-bridge serial control block
// sees only the top module's ports; bound at the foot of the file
`timescale 1ns/10ps
`default_nettype none
module hb_spi_control_sva
  import hb_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              chip_select_n,
  input wire logic              serial_out,
  input wire logic              serial_out_en,
  input wire logic              enable,
  input wire hb_fault_t         fault_in,
  input wire logic [NUM_CH-1:0] low_side,
  input wire logic [NUM_CH-1:0] high_side
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [5:0] lo_off;
  logic [5:0] hi_off;
  // cycles since channel 1 low and high sides were last on, saturating
  always_ff @(posedge clk) begin
    lo_off <= !resetn ? 6'h3F : low_side[0] ? 6'h00 : lo_off + {5'h00, lo_off != 6'h3F};
    hi_off <= !resetn ? 6'h3F : high_side[0] ? 6'h00 : hi_off + {5'h00, hi_off != 6'h3F};
  end
  // output release, sleep and undervoltage
  so_release_a: assert property (chip_select_n |-> !serial_out_en)
    else $error("serial output driven while deselected");
  sleep_off_a: assert property (!enable [*4] |=> low_side == 6'h00 && high_side == 6'h00)
    else $error("drivers on while asleep");
  sleep_quiet_a: assert property (!enable [*4] |-> !serial_out_en)
    else $error("serial output driven while asleep");
  uv_off_a: assert property (fault_in.undervoltage [*4] |=> low_side == 6'h00)
    else $error("low side on during supply fault");
  // dead time on channel 1, shoot-through on every channel
  dead_lh_a: assert property ($rose(high_side[0]) |-> lo_off >= 6'h19)
    else $error("high side on too soon after low side off");
  dead_hl_a: assert property ($rose(low_side[0]) |-> hi_off >= 6'h0F)
    else $error("low side on too soon after high side off");
  no_shoot_a: assert property ((low_side & high_side) == 6'h00)
    else $error("both sides of a channel on");
  // thermal flag shown as soon as select falls
  tw_at_sel_a: assert property ((enable && fault_in.thermal_warning) [*4] ##1
    $fell(chip_select_n) |-> serial_out && serial_out_en)
    else $error("thermal flag missing at select");
  // main scenarios
  cover property ($rose(high_side[0]));
  cover property ($fell(chip_select_n) && serial_out);
  cover property (!enable [*4]);
endmodule
bind hb_spi_control hb_spi_control_sva chk_u (.clk(clk), .resetn(resetn),
  .chip_select_n(chip_select_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
  .enable(enable), .fault_in(fault_in), .low_side(low_side), .high_side(high_side));
`default_nettype wire

// [testbench.sv]
// self-checking bench for the half-bridge serial control block
// host model drives the link; bench drives clock, reset, enable, faults
`timescale 1ns/10ps
`default_nettype none
module testbench
  import hb_pkg::*;
;
  logic              clk, resetn, enable, sclk, chip_select_n, serial_in;
  logic              serial_out, serial_out_en, e;
  hb_fault_t         fault_in;
  logic [NUM_CH-1:0] low_side, high_side;
  logic [31:0]       st;
  logic [15:0]       c, p;
  int                n_errors, cmp_count, b;

  hb_spi_control dut_u (.clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .enable(enable), .fault_in(fault_in), .low_side(low_side), .high_side(high_side));
  hb_host_model host_u (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // drivers against the switch bits of a command word
  task automatic chk_drv(input logic [15:0] cmd);
    logic [15:0] x;
    x = 16'h0000;
    for (int k = 0; k < NUM_CH; k++) begin
      x[k] = cmd[2*k+1];
      x[k+8] = cmd[2*k+2];
    end
    check({2'h0, high_side, 2'h0, low_side}, x);
  endtask
  task automatic fr(input logic [31:0] cmd, input int n);
    host_u.xfer(cmd, n, st);
    cyc(6);
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #3000000;
    n_errors++;
    complete_run();
  end
  initial begin
    n_errors = 0;
    cmp_count = 0;
    resetn = 1'b0;
    enable = 1'b1;
    fault_in = '0;
    p = 16'h0000;
    cyc(6);
    resetn = 1'b1;
    cyc(6);
    // each driver alone; the status word shows the previous command
    for (int i = 1; i <= NUM_DRV; i++) begin
      c = 16'h0001 << i;
      fr({16'h0000, c}, 16);
      check(st[15:0] & 16'h1FFE, p);
      p = c;
      cyc(45);
      chk_drv(c);
    end
    fr(32'h0000_0004, 8);
    cyc(45);
    chk_drv(16'h1000);
    fr(32'h0002_0008, 32);
    cyc(45);
    chk_drv(16'h0002);
    check(st[31:16], 16'h0008);
    // thermal flag latches past cooling until cleared
    fault_in.thermal_warning = 1'b1;
    cyc(6);
    fr(32'h0000_0002, 16);
    check({15'h0000, st[0]}, 16'h0001);
    fault_in.thermal_warning = 1'b0;
    cyc(6);
    fr(32'h0000_0003, 16);
    check({15'h0000, st[0]}, 16'h0001);
    fr(32'h0000_0002, 16);
    check({15'h0000, st[0]}, 16'h0000);
    // supply, overcurrent and under-load faults, shutdown disabled then enabled
    for (int k = 0; k < 6; k++) begin
      b = (k < 2) ? 15 : (k < 4) ? 13 : 14;
      e = k[0];
      c = 16'h0002 | (16'(e) << b);
      fr({16'h0000, c}, 16);
      cyc(45);
      if (b == 15) fault_in.overvoltage = 1'b1;
      else if (b == 13) fault_in.overcurrent[0] = 1'b1;
      else fault_in.underload[0] = 1'b1;
      if (b == 14) begin
        cyc(3000);
        chk_drv(c);
        cyc(600);
      end else cyc(10);
      chk_drv(e ? 16'h0000 : c);
      fault_in = '0;
      cyc(45);
      chk_drv((e && b != 15) ? 16'h0000 : c);
      fr(32'h0000_0001, 16);
      check(st[15:0] & (16'h0001 << b), 16'h0001 << b);
      cyc(45);
    end
    fr(32'h0000_0002, 16);
    cyc(45);
    fault_in.undervoltage = 1'b1;
    cyc(6);
    chk_drv(16'h0000);
    fault_in.undervoltage = 1'b0;
    cyc(45);
    // sleep drops commands and flags
    enable = 1'b0;
    cyc(8);
    fr(32'h0000_0002, 16);
    chk_drv(16'h0000);
    enable = 1'b1;
    cyc(8);
    fr(32'h0000_0000, 16);
    check(st[15:0], 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
